/* File: bench/sbm_modem_model.sv */
// modem side model: drives the four status pins and the speed indicator
`timescale 1ns/10ps
module sbm_modem_model (
  output logic o_cts_pin,
  output logic o_dsr_pin,
  output logic o_ri_pin,
  output logic o_dcd_pin,
  output logic o_speed_ind
);
  // pins idle high (lines negated at the connector), speed indicator not asserted
  logic [4:0] lvl = 5'h0f;
  assign {o_speed_ind, o_dcd_pin, o_ri_pin, o_dsr_pin, o_cts_pin} = lvl;
  task automatic set_line(input int idx, input logic v);
    lvl[idx] = v;
  endtask
endmodule

/* File: bench/sbm_top_asserts.sv */
// concurrent checks on the serial support top level
`timescale 1ns/10ps
module sbm_top_asserts (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic [15:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] o_io_rdata,
  input wire logic o_io_rd_hit,
  input wire logic i_cts_pin,
  input wire logic i_dsr_pin,
  input wire logic i_ri_pin,
  input wire logic i_dcd_pin,
  input wire logic i_speed_ind,
  input wire logic i_fd_wprot,
  input wire logic i_fd_track0,
  input wire logic i_fd_index,
  input wire logic o_speed_select,
  input wire logic o_ports_detach_from_io,
  input wire logic o_video_enable,
  input wire logic o_modem_irq,
  input wire logic o_controller_baud_output,
  input wire logic o_rx_clk16,
  input wire logic o_tx_clk16,
  input wire logic [15:0] o_divisor,
  input wire logic o_dlab
);
  localparam logic [15:0] UB = sbm_pkg::UART_BASE_DEF;
  wire logic [3:0] pins = {i_dcd_pin, i_ri_pin, i_dsr_pin, i_cts_pin};
  wire logic [3:0] sts = {i_fd_wprot, i_fd_track0, i_fd_index, !i_speed_ind};
  wire logic on = i_clk_en && !o_ports_detach_from_io;
  wire logic spr_wr = i_clk_en && i_io_wr && i_io_addr == sbm_pkg::SPR_ADDR;
  wire logic spr_rd = i_clk_en && i_io_rd && i_io_addr == sbm_pkg::SPR_ADDR;
  wire logic msr_rd = on && i_io_rd && i_io_addr == UB + 16'h0006;
  wire logic lo_wr = on && o_dlab && i_io_wr && i_io_addr == UB;
  // split bit as last written, tracked from the bus
  logic split_seen;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      split_seen <= 1'b0;
    end else if (spr_wr) begin
      split_seen <= i_io_wdata[2];
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////
  a_speed_sel_drive:
    assert property (spr_wr |=> o_speed_select == !$past(i_io_wdata[0])) else $error("speed sel");
  a_detach_drive:
    assert property (spr_wr |=> o_ports_detach_from_io == $past(i_io_wdata[1])) else $error("detach");
  a_video_drive:
    assert property (spr_wr |=> o_video_enable == $past(i_io_wdata[3])) else $error("video");
  a_irq_flag_or:
    assert property ($past(msr_rd) && o_io_rd_hit |-> $past(o_modem_irq) == (|o_io_rdata[3:0]))
    else $error("irq vs flags");
  a_lines_inverted:
    assert property ($past(msr_rd) && o_io_rd_hit && $past(i_clk_en, 2)
      |-> o_io_rdata[7:4] == ~$past(pins, 2)) else $error("line states");
  // a read with no pin change nearby must leave every change flag clear
  a_read_clears_flags:
    assert property (msr_rd && $past(pins) == pins && $past(pins, 2) == pins |=> !o_modem_irq)
    else $error("read clear");
  a_lo_byte_load:
    assert property (lo_wr |=> o_divisor[7:0] == $past(i_io_wdata)) else $error("low byte");
  a_tx_programmed:
    assert property (o_tx_clk16 == o_controller_baud_output &&
      ($past(split_seen) || o_rx_clk16 == o_controller_baud_output)) else $error("tx clock");
  a_baud_one_cycle:
    assert property (o_controller_baud_output |=> !o_controller_baud_output) else $error("pulse");
  a_spr_status:
    assert property ($past(spr_rd) && $past(sts) == $past(sts, 2)
      |-> o_io_rd_hit && o_io_rdata[7:4] == $past(sts)) else $error("spr status");
  c_msr_irq_read: cover property (msr_rd && o_modem_irq);
  c_spr_write: cover property (spr_wr);
  c_split_rx: cover property (o_rx_clk16 && !o_controller_baud_output);
endmodule
bind sbm_top sbm_top_asserts sbm_top_asserts_inst (.*);

/* File: bench/sbm_top_test.sv */
// self-checking bench for the serial support top level
`timescale 1ns/10ps
module sbm_top_test;
  localparam logic [15:0] UB = sbm_pkg::UART_BASE_DEF;
  localparam logic [15:0] SPR = sbm_pkg::SPR_ADDR;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [15:0] i_io_addr = 16'h0000;
  logic [7:0] i_io_wdata = 8'h00;
  logic i_io_wr = 1'b0;
  logic i_io_rd = 1'b0;
  logic i_fd_wprot = 1'b1;
  logic i_fd_track0 = 1'b0;
  logic i_fd_index = 1'b1;
  wire logic i_cts_pin, i_dsr_pin, i_ri_pin, i_dcd_pin, i_speed_ind;
  wire logic [7:0] o_io_rdata;
  wire logic [15:0] o_divisor;
  wire logic o_io_rd_hit, o_speed_select, o_ports_detach_from_io, o_video_enable;
  wire logic o_modem_irq, o_controller_baud_output, o_rx_clk16, o_tx_clk16, o_dlab;
  int errors = 0;
  int checks_done = 0;
  logic [15:0] dv [3];
  logic [7:0] rv;
  logic h;
  logic [3:0] p, e;
  sbm_top sbm_top_inst (.i_clk_en(1'b1), .*);
  sbm_modem_model sbm_modem_model_inst (.o_cts_pin(i_cts_pin), .o_dsr_pin(i_dsr_pin),
    .o_ri_pin(i_ri_pin), .o_dcd_pin(i_dcd_pin), .o_speed_ind(i_speed_ind));
  initial begin
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    i_io_addr = a;
    i_io_wdata = d;
    i_io_wr = 1'b1;
    @(negedge i_core_clk);
    i_io_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic hit);
    @(negedge i_core_clk);
    i_io_addr = a;
    i_io_rd = 1'b1;
    @(negedge i_core_clk);
    i_io_rd = 1'b0;
    d = o_io_rdata;
    hit = o_io_rd_hit;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] ed, input logic eh);
    logic [7:0] d;
    logic hit;
    rd(a, d, hit);
    chk({hit, 7'h00, d}, {eh, 7'h00, ed});
  endtask
  task automatic outs(input logic [3:0] ex);
    chk({12'h000, o_speed_select, o_ports_detach_from_io, o_video_enable, o_dlab}, {12'h000, ex});
  endtask
  function automatic logic pick(input int sel);
    return sel == 0 ? o_controller_baud_output : (sel == 1 ? o_rx_clk16 : o_tx_clk16);
  endfunction
  // the reference is an averaged tick, so one period may run one cycle long
  task automatic chk_per(input int sel, input int div);
    int n;
    int w;
    longint ex;
    ex = longint'(sbm_pkg::CORE_HZ) * div / sbm_pkg::REF_HZ;
    n = 0;
    w = 0;
    @(negedge i_core_clk);
    while (!pick(sel) && w < 30000) begin
      @(negedge i_core_clk);
      w++;
    end
    do begin
      @(negedge i_core_clk);
      n++;
    end while (!pick(sel) && n < 30000);
    chk(16'((n == ex || n == ex + 1) ? ex : n), 16'(ex));
  endtask
  task automatic tally_and_finish;
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    errors++;
    $display("watchdog expired");
    tally_and_finish();
  end
  initial begin
    repeat (8) @(negedge i_core_clk);
    i_rst = 1'b0;
    rdc(SPR, 8'hb9, 1'b1);
    outs(4'h2);
    rdc(UB + 16'h0006, 8'h00, 1'b1);
    $display("reset test done");
    dv = '{16'hffff, 16'(sbm_pkg::REF_HZ / 16 / 9600), 16'(sbm_pkg::REF_HZ / 16 / 38400)};
    wr(UB + 16'h0003, 8'h80);
    foreach (dv[k]) begin
      wr(UB, dv[k][7:0]);
      wr(UB + 16'h0001, dv[k][15:8]);
      rdc(UB, dv[k][7:0], 1'b1);
      rdc(UB + 16'h0001, dv[k][15:8], 1'b1);
      chk(o_divisor, dv[k]);
    end
    wr(UB + 16'h0003, 8'h00);
    outs(4'h2);
    $display("divisor test done");
    p = 4'hf;
    for (int i = 0; i < 4; i++) begin
      for (int v = 0; v < 2; v++) begin
        @(negedge i_core_clk);
        sbm_modem_model_inst.set_line(i, v[0]);
        p[i] = v[0];
        repeat (3) @(negedge i_core_clk);
        e = (v == 1 && i == 2) ? 4'h0 : 4'h1 << i;
        chk({15'h0000, o_modem_irq}, {15'h0000, |e});
        rdc(UB + 16'h0006, {~p, e}, 1'b1);
        rdc(UB + 16'h0006, {~p, 4'h0}, 1'b1);
        chk({15'h0000, o_modem_irq}, 16'h0000);
      end
    end
    $display("modem status test done");
    wr(SPR, 8'hf6);
    sbm_modem_model_inst.set_line(4, 1'b1);
    rdc(SPR, 8'ha6, 1'b1);
    outs(4'hc);
    rdc(UB + 16'h0006, 8'h00, 1'b0);
    rd(SPR, rv, h);
    wr(SPR, (rv & 8'hfc) | 8'h01);
    outs(4'h0);
    rdc(UB + 16'h0006, 8'h00, 1'b1);
    $display("special register test done");
    chk_per(2, 3);
    chk_per(1, 96);
    wr(SPR, 8'h09);
    chk_per(1, 3);
    chk_per(0, 3);
    $display("baud test done");
    tally_and_finish();
  end
endmodule

/* File: verilog/sbm_baud_gen.sv */
// baud rate generator with fixed 1200 baud split receive clock
`timescale 1ns/10ps
module sbm_baud_gen #(
  parameter int CORE_HZ = sbm_pkg::CORE_HZ,
  parameter int REF_HZ = sbm_pkg::REF_HZ
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  sbm_core_if.baud bif
);
  localparam logic [sbm_pkg::ACC_W-1:0] REF_STEP = sbm_pkg::ACC_W'(REF_HZ);
  localparam logic [sbm_pkg::ACC_W-1:0] CORE_MOD = sbm_pkg::ACC_W'(CORE_HZ);
  localparam logic [sbm_pkg::SPLIT_W-1:0] SPLIT_LAST =
    sbm_pkg::SPLIT_W'(sbm_pkg::SPLIT_DIV - 1);

  logic [sbm_pkg::ACC_W-1:0] acc_q;
  logic [sbm_pkg::ACC_W-1:0] acc_sum;
  logic ref_tick;
  logic [15:0] cnt_q;
  logic [sbm_pkg::SPLIT_W-1:0] split_q;
  logic prog_wrap;
  logic split_wrap;
  logic prog_q;
  logic rx_q;

  // fractional accumulator: 1.8432 mhz reference ticks from the core clock
  assign acc_sum = acc_q + REF_STEP;
  assign ref_tick = (acc_sum >= CORE_MOD);
  // a divisor of zero stops the generator; >= copes with a divisor lowered mid-count
  assign prog_wrap = ref_tick && (bif.divisor != 16'h0000) &&
    (cnt_q >= bif.divisor - 16'h0001);
  assign split_wrap = ref_tick && (split_q == SPLIT_LAST);
  assign bif.controller_baud_output = prog_q;
  assign bif.tx_tick = prog_q;
  assign bif.rx_tick = rx_q;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      acc_q <= '0;
      cnt_q <= 16'h0000;
      split_q <= '0;
      prog_q <= 1'b0;
      rx_q <= 1'b0;
    end else if (i_clk_en) begin
      acc_q <= ref_tick ? acc_sum - CORE_MOD : acc_sum;
      if (prog_wrap || bif.divisor == 16'h0000) begin
        cnt_q <= 16'h0000;
      end else if (ref_tick) begin
        cnt_q <= cnt_q + 16'h0001;
      end
      if (ref_tick) begin
        split_q <= split_wrap ? '0 : split_q + 1'b1;
      end
      // each pulse is one of sixteen per serial bit
      prog_q <= prog_wrap;
      rx_q <= bif.split ? split_wrap : prog_wrap;
    end
  end
endmodule

/* File: verilog/sbm_core_if.sv */
// carrier between the top level and its modem and baud submodules
`timescale 1ns/10ps
interface sbm_core_if;
  logic [3:0] line;
  logic rd_clr;
  logic [7:0] msr;
  logic [15:0] divisor;
  logic split;
  logic controller_baud_output;
  logic rx_tick;
  logic tx_tick;
  modport modem (input line, input rd_clr, output msr);
  modport baud (input divisor, input split, output controller_baud_output,
    output rx_tick, output tx_tick);
  modport top (output line, output rd_clr, input msr, output divisor,
    output split, input controller_baud_output, input rx_tick, input tx_tick);
endinterface

/* File: verilog/sbm_modem_status.sv */
// modem line state capture and change flags
`timescale 1ns/10ps
module sbm_modem_status (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  sbm_core_if.modem mif
);
  logic [3:0] prev_q;
  logic [3:0] delta_q;
  logic [3:0] delta_d;
  logic [3:0] change;
  logic [3:0] set;
  logic primed_q;

  // the first sample after reset only loads the history, it flags nothing
  assign change = primed_q ? (mif.line ^ prev_q) : 4'h0;
  assign set[sbm_pkg::MSR_DCTS] = change[sbm_pkg::LINE_CTS];
  assign set[sbm_pkg::MSR_DDSR] = change[sbm_pkg::LINE_DSR];
  assign set[sbm_pkg::MSR_TERI] = change[sbm_pkg::LINE_RI] &
    mif.line[sbm_pkg::LINE_RI];
  assign set[sbm_pkg::MSR_DDCD] = change[sbm_pkg::LINE_DCD];
  // a change landing in the read cycle survives the clear
  assign delta_d = (delta_q & ~{4{mif.rd_clr}}) | set;
  assign mif.msr = {prev_q, delta_q};

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      prev_q <= 4'h0;
      delta_q <= 4'h0;
      primed_q <= 1'b0;
    end else if (i_clk_en) begin
      prev_q <= mif.line;
      delta_q <= delta_d;
      primed_q <= 1'b1;
    end
  end
endmodule

/* File: verilog/sbm_pkg.sv */
// constants shared by the serial baud and modem status block
package sbm_pkg;
  localparam int IO_AW = 16;
  localparam logic [15:0] UART_BASE_DEF = 16'h03f8;
  localparam logic [15:0] SPR_ADDR = 16'h0c80;
  // uart register offsets from the port base
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IER = 3'h1;
  localparam logic [2:0] OFS_LCR = 3'h3;
  localparam logic [2:0] OFS_MSR = 3'h6;
  localparam int LCR_DLAB_BIT = 7;
  localparam logic [7:0] LCR_RESET = 8'h00;
  localparam logic [7:0] IER_RESET = 8'h00;
  localparam logic [7:0] IER_MASK = 8'h0f;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  // modem status: deltas in [3:0], line states in [7:4]
  localparam int MSR_DCTS = 0;
  localparam int MSR_DDSR = 1;
  localparam int MSR_TERI = 2;
  localparam int MSR_DDCD = 3;
  localparam int LINE_CTS = 0;
  localparam int LINE_DSR = 1;
  localparam int LINE_RI = 2;
  localparam int LINE_DCD = 3;
  // special purpose register fields
  localparam int SPR_SPEED_SEL = 0;
  localparam int SPR_DETACH = 1;
  localparam int SPR_SPLIT = 2;
  localparam int SPR_VIDEO = 3;
  localparam int SPR_SPEED_IND = 4;
  localparam int SPR_INDEX = 5;
  localparam int SPR_TRACK0 = 6;
  localparam int SPR_WPROT = 7;
  localparam logic [3:0] SPR_RESET = 4'h9;
  // clocking figures
  localparam int CORE_HZ = 200000000;
  localparam int REF_HZ = 1843200;
  localparam int ACC_W = 28;
  localparam int OVERSAMPLE = 16;
  localparam int SPLIT_BAUD = 1200;
  localparam int SPLIT_DIV = REF_HZ / OVERSAMPLE / SPLIT_BAUD;
  localparam int SPLIT_W = 7;
endpackage

/* File: verilog/sbm_top.sv */
// serial port support: divisor latch, modem status and special purpose register
`timescale 1ns/10ps

// What this block does
// - modem status bit 1 flags a data set ready change; read clears it
// - modem status bit 0 flags a clear to send change; read clears it
// - any set change flag in bits 3..0 raises the modem interrupt
// - bits 7..4 are inverted pin levels, showing true connector states
// - with divisor access set, data and enable offsets reach the divisor bytes
// - divisor is sixteen bits from two byte latches, range 1 to 65535
// - generator output is the 1.8432 mhz reference over the divisor
// - generator output runs at sixteen times the bit rate
// - speed select and indicator live in the register at 0c80
// - receive clock selects controller baud output or a fixed 1200 baud counter
// - split bit clear: both use programmed rate; set: receive at 1200
// - bit 1 zero keeps the ports in io space, one detaches them
// - bit 0 drives speed select: zero asserts, one deasserts
// - bit 4 reads zero when speed indicator is asserted, else one
// - bits 7..5 report write protect, track zero and index hole
// - bit 3 writes zero to disable video, one to enable
// - modem status bit 3 flags a carrier detect change; read clears it
// - modem status bit 2 flags a rising ring indicator; read clears it
module sbm_top #(
  parameter logic [15:0] UART_BASE = sbm_pkg::UART_BASE_DEF,
  parameter logic [15:0] SPR_BASE = sbm_pkg::SPR_ADDR
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic [15:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  output logic [7:0] o_io_rdata,
  output logic o_io_rd_hit,
  input wire logic i_cts_pin,
  input wire logic i_dsr_pin,
  input wire logic i_ri_pin,
  input wire logic i_dcd_pin,
  input wire logic i_speed_ind,
  input wire logic i_fd_wprot,
  input wire logic i_fd_track0,
  input wire logic i_fd_index,
  output logic o_speed_select,
  output logic o_ports_detach_from_io,
  output logic o_video_enable,
  output logic o_modem_irq,
  output logic o_controller_baud_output,
  output logic o_rx_clk16,
  output logic o_tx_clk16,
  output logic [15:0] o_divisor,
  output logic o_dlab
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  // true when the address falls at the given uart offset
  function automatic logic uart_at(input logic [15:0] addr,
                                   input logic [15:0] base,
                                   input logic [2:0] ofs);
    uart_at = (addr == base + {13'h0000, ofs});
  endfunction

  sbm_core_if cif ();

  logic [7:0] lcr_q;
  logic [7:0] ier_q;
  logic [7:0] div_lo_q;
  logic [7:0] div_hi_q;
  logic [3:0] spr_q;
  logic [7:0] rdata_q;
  logic hit_q;

  logic dlab;
  logic attached;
  logic sel_data;
  logic sel_ier;
  logic sel_lcr;
  logic sel_msr;
  logic sel_spr;
  logic sel_div_lo;
  logic sel_div_hi;
  logic sel_ier_reg;
  logic rd_en;
  logic wr_en;
  logic any_hit;
  logic [7:0] spr_view;
  logic [7:0] rd_mux;

  assign dlab = lcr_q[sbm_pkg::LCR_DLAB_BIT];
  // detached ports neither answer reads nor take writes
  assign attached = ~spr_q[sbm_pkg::SPR_DETACH];
  assign rd_en = i_io_rd & i_clk_en;
  assign wr_en = i_io_wr & i_clk_en;

  // the four uart offsets decode alike, so one loop serves them
  localparam logic [2:0] UART_OFS [4] = '{sbm_pkg::OFS_DATA, sbm_pkg::OFS_IER,
    sbm_pkg::OFS_LCR, sbm_pkg::OFS_MSR};
  logic [3:0] sel_uart;
  for (genvar k = 0; k < 4; k++) begin : g_uart_sel
    assign sel_uart[k] = attached & uart_at(i_io_addr, UART_BASE, UART_OFS[k]);
  end
  assign sel_data = sel_uart[0];
  assign sel_ier = sel_uart[1];
  assign sel_lcr = sel_uart[2];
  assign sel_msr = sel_uart[3];
  // the special purpose register stays reachable even while detached
  assign sel_spr = (i_io_addr == SPR_BASE);

  // divisor access bit steers the two low offsets onto the latch bytes
  assign sel_div_lo = sel_data & dlab;
  assign sel_div_hi = sel_ier & dlab;
  assign sel_ier_reg = sel_ier & ~dlab;

  assign any_hit = sel_data | sel_ier | sel_lcr | sel_msr | sel_spr;

  ////////////////////////////////////////////////////////////////////////////
  // write strobes per register

  logic we_lcr;
  logic we_ier;
  logic we_div_lo;
  logic we_div_hi;
  logic we_spr;

  // strobes carry the enable, so a frozen block ignores the bus
  assign we_lcr = wr_en & sel_lcr;
  assign we_ier = wr_en & sel_ier_reg;
  assign we_div_lo = wr_en & sel_div_lo;
  assign we_div_hi = wr_en & sel_div_hi;
  assign we_spr = wr_en & sel_spr;

  ////////////////////////////////////////////////////////////////////////////
  // special purpose register view

  assign spr_view[sbm_pkg::SPR_SPEED_SEL] = spr_q[sbm_pkg::SPR_SPEED_SEL];
  assign spr_view[sbm_pkg::SPR_DETACH] = spr_q[sbm_pkg::SPR_DETACH];
  assign spr_view[sbm_pkg::SPR_SPLIT] = spr_q[sbm_pkg::SPR_SPLIT];
  assign spr_view[sbm_pkg::SPR_VIDEO] = spr_q[sbm_pkg::SPR_VIDEO];
  assign spr_view[sbm_pkg::SPR_SPEED_IND] = ~i_speed_ind;
  assign spr_view[sbm_pkg::SPR_INDEX] = i_fd_index;
  assign spr_view[sbm_pkg::SPR_TRACK0] = i_fd_track0;
  assign spr_view[sbm_pkg::SPR_WPROT] = i_fd_wprot;

  ////////////////////////////////////////////////////////////////////////////
  // read selection

  // the receive path is outside this block, so the data offset reads zero
  // unless the divisor latch is mapped over it
  logic [7:0] rd_div_lo;
  logic [7:0] rd_div_hi;
  logic [7:0] rd_ier;
  logic [7:0] rd_lcr;
  logic [7:0] rd_msr;
  logic [7:0] rd_spr;

  assign rd_div_lo = sel_div_lo ? div_lo_q : 8'h00;
  assign rd_div_hi = sel_div_hi ? div_hi_q : 8'h00;
  assign rd_ier = sel_ier_reg ? (ier_q & sbm_pkg::IER_MASK) : 8'h00;
  assign rd_lcr = sel_lcr ? lcr_q : 8'h00;
  assign rd_msr = sel_msr ? cif.msr : 8'h00;
  assign rd_spr = sel_spr ? spr_view : 8'h00;
  // selects are one-hot while the special register address misses the four uart offsets, so an or of the terms is the mux
  assign rd_mux = rd_div_lo | rd_div_hi | rd_ier | rd_lcr | rd_msr | rd_spr;

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      lcr_q <= sbm_pkg::LCR_RESET;
    end else if (we_lcr) begin
      lcr_q <= i_io_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ier_q <= sbm_pkg::IER_RESET;
    end else if (we_ier) begin
      ier_q <= i_io_wdata & sbm_pkg::IER_MASK;
    end
  end

  // the two latch bytes load independently; software may write either first
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      div_lo_q <= sbm_pkg::DIV_RESET[7:0];
    end else if (we_div_lo) begin
      div_lo_q <= i_io_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      div_hi_q <= sbm_pkg::DIV_RESET[15:8];
    end else if (we_div_hi) begin
      div_hi_q <= i_io_wdata;
    end
  end

  // bits 7..4 of a write are dropped: they only report inputs
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      spr_q <= sbm_pkg::SPR_RESET;
    end else if (we_spr) begin
      spr_q <= i_io_wdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  logic [7:0] rdata_d;
  logic hit_d;

  // a read with the enable low is not taken, so it neither answers nor clears
  assign rdata_d = i_io_rd ? rd_mux : 8'h00;
  assign hit_d = i_io_rd & any_hit;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
      hit_q <= 1'b0;
    end else if (i_clk_en) begin
      rdata_q <= rdata_d;
      hit_q <= hit_d;
    end
  end

  assign o_io_rdata = rdata_q;
  assign o_io_rd_hit = hit_q;

  ////////////////////////////////////////////////////////////////////////////
  // modem status

  // pins carry the inverted line, so the register holds their complement
  logic [3:0] pin_vec;
  assign pin_vec[sbm_pkg::LINE_CTS] = i_cts_pin;
  assign pin_vec[sbm_pkg::LINE_DSR] = i_dsr_pin;
  assign pin_vec[sbm_pkg::LINE_RI] = i_ri_pin;
  assign pin_vec[sbm_pkg::LINE_DCD] = i_dcd_pin;
  for (genvar k = 0; k < 4; k++) begin : g_line_inv
    assign cif.line[k] = ~pin_vec[k];
  end
  assign cif.rd_clr = rd_en & sel_msr;

  sbm_modem_status u_modem (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .mif(cif.modem)
  );

  assign o_modem_irq = |cif.msr[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // baud generation

  assign cif.divisor = {div_hi_q, div_lo_q};
  assign cif.split = spr_q[sbm_pkg::SPR_SPLIT];

  sbm_baud_gen u_baud (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .bif(cif.baud)
  );

  assign o_controller_baud_output = cif.controller_baud_output;
  assign o_rx_clk16 = cif.rx_tick;
  assign o_tx_clk16 = cif.tx_tick;

  ////////////////////////////////////////////////////////////////////////////
  // board controls

  // speed select keeps its own flop so the line comes straight off a register
  logic speed_sel_q;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      speed_sel_q <= ~sbm_pkg::SPR_RESET[sbm_pkg::SPR_SPEED_SEL];
    end else if (we_spr) begin
      speed_sel_q <= ~i_io_wdata[sbm_pkg::SPR_SPEED_SEL];
    end
  end

  assign o_speed_select = speed_sel_q;
  assign o_ports_detach_from_io = spr_q[sbm_pkg::SPR_DETACH];
  assign o_video_enable = spr_q[sbm_pkg::SPR_VIDEO];
  assign o_divisor = {div_hi_q, div_lo_q};
  assign o_dlab = dlab;

endmodule
